//--- common/rxexc_pkg.sv
// rxexc_pkg: constants, register indices and carrier structs for the
// receive-enable mask byte and exception flag bank.
// assumes a single 250 MHz device clock and an APB register port.
`default_nettype none

package rxexc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_MASK_HIGH  = 6'h0f;
    localparam logic [5:0] IDX_FLAGS_LOW  = 6'h10;
    localparam logic [5:0] IDX_FLAGS_HIGH = 6'h11;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h12;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h13;

    localparam logic [7:0]  RST_MASK_HIGH = 8'h00;
    localparam logic [15:0] RST_FLAGS     = 16'h0000;
    localparam logic [15:0] RST_IRQ       = 16'h0000;

    // exception positions in the low flag byte
    localparam int unsigned EXC_RADIO_IDLE     = 0;
    localparam int unsigned EXC_TX_FRAME_DONE  = 1;
    localparam int unsigned EXC_TX_ACK_DONE    = 2;
    localparam int unsigned EXC_TX_UNDERFLOW   = 3;
    localparam int unsigned EXC_TX_OVERFLOW    = 4;
    localparam int unsigned EXC_RX_UNDERFLOW   = 5;
    localparam int unsigned EXC_RX_OVERFLOW    = 6;
    localparam int unsigned EXC_MASK_CLEARED   = 7;

    // mask bits 15, 14 and 13 as seen inside the high byte
    localparam int unsigned HI_BIT_RX_ON  = 7;
    localparam int unsigned HI_BIT_TX_ON  = 6;
    localparam int unsigned HI_BIT_AUX    = 5;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } rxexc_apb_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } rxexc_apb_rsp_s;

    // internal sources that modify the mask
    typedef struct packed {
        logic       radio_off_strobe;
        logic       rx_on_strobe;
        logic       tx_on_strobe;
        logic       mask_or;
        logic       mask_and;
        logic       aux_bit_set;
        logic       aux_bit_clr;
        logic [7:0] operand;
    } rxexc_strobe_s;

    typedef struct packed {
        rxexc_apb_rsp_s rsp;
        logic [7:0]     mask_hi;
        logic [15:0]    flags;
        logic [15:0]    irq_sts;
        logic [15:0]    irq_msk;
        logic           irq;
        logic           rx_enable;
        logic           was_nonzero;
    } rxexc_state_s;

endpackage : rxexc_pkg

`default_nettype wire

//--- core/rxexc_top.sv
// rxexc_top: upper receive-enable mask byte, exception pending flags,
// interrupt status/mask and an APB slave giving access to them.
// assumes all inputs come from logic on clk_i; the low mask byte is
// kept elsewhere and arrives on mask_low_i.
//
// Behaviour
// [RULE1] mask bits 15:8 live in their own read/write byte register.
// [RULE2] the upper mask byte is zero after reset.
// [RULE3] each listed exception event sets its pending flag in hardware.
// [RULE4] software clears a flag only by writing zero; a one leaves it.
// [RULE5] a flag at one means its event happened and was not cleared.
// [RULE6] low flags 0..7: idle, tx, ack, txund, txovf, rxund, rxovf, mask0.
// [RULE7] the low flag byte sits at index 0x10 and resets to zero.
// [RULE8] a non-zero 16-bit mask requests the receiver to be on.
// [RULE9] the radio-off strobe clears the mask and beats every other strobe.
// [RULE10] a host bus write to the mask beats every internal source.
// [RULE11] an event in the same cycle as a software clear keeps the flag set.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none

module rxexc_top (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire rxexc_pkg::rxexc_apb_req_s apb_i,
    output var  rxexc_pkg::rxexc_apb_rsp_s apb_o,
    input  wire rxexc_pkg::rxexc_strobe_s  strobe_i,
    input  wire logic                      tx_on_sets_mask_i,
    input  wire logic [7:0]                mask_low_i,
    input  wire logic [15:0]               event_i,
    output logic [7:0]                     mask_high_o,
    output logic [15:0]                    flags_o,
    output logic                           rx_enable_o,
    output logic                           irq_o
);

    rxexc_pkg::rxexc_state_s s_q;
    rxexc_pkg::rxexc_state_s s_d;

    logic        access;
    logic        take;
    logic        wr;
    logic [5:0]  idx;
    logic [15:0] full_mask;
    logic [15:0] ev;
    logic [7:0]  m;

    function automatic logic hit(input logic [rxexc_pkg::ADDR_W-1:0] a);
        logic [5:0] i;
        i = a[7:2];
        hit = (a[1:0] == 2'h0) &&
              (i == rxexc_pkg::IDX_MASK_HIGH  ||
               i == rxexc_pkg::IDX_FLAGS_LOW  ||
               i == rxexc_pkg::IDX_FLAGS_HIGH ||
               i == rxexc_pkg::IDX_IRQ_STATUS ||
               i == rxexc_pkg::IDX_IRQ_MASK);
    endfunction : hit

    function automatic logic [31:0] rd(input logic [5:0] i,
                                       input rxexc_pkg::rxexc_state_s s);
        rd = 32'h0000_0000;
        case (i)
            rxexc_pkg::IDX_MASK_HIGH:  rd[7:0]  = s.mask_hi;
            rxexc_pkg::IDX_FLAGS_LOW:  rd[7:0]  = s.flags[7:0];
            rxexc_pkg::IDX_FLAGS_HIGH: rd[7:0]  = s.flags[15:8];
            rxexc_pkg::IDX_IRQ_STATUS: rd[15:0] = s.irq_sts;
            rxexc_pkg::IDX_IRQ_MASK:   rd[15:0] = s.irq_msk;
            default:                   rd = 32'h0000_0000;
        endcase
    endfunction : rd

    assign access    = apb_i.psel & apb_i.penable;
    // the transfer completes at the edge where our pready is already high
    assign take      = access & s_q.rsp.pready;
    assign wr        = take & apb_i.pwrite & hit(apb_i.paddr);
    assign idx       = apb_i.paddr[7:2];
    assign full_mask = {s_q.mask_hi, mask_low_i};

    // the mask-zero event is made here; its input bit is ignored
    always_comb
    begin
        ev = event_i; // RULE3
        ev[rxexc_pkg::EXC_MASK_CLEARED] =
            s_q.was_nonzero & (full_mask == 16'h0000); // RULE6
    end

    always_comb
    begin
        s_d = s_q;

        // one wait state: pready rises in the second access cycle
        s_d.rsp.pready  = access & ~s_q.rsp.pready;
        s_d.rsp.prdata  = 32'h0000_0000;
        s_d.rsp.pslverr = 1'b0;
        if (access && !s_q.rsp.pready)
        begin
            s_d.rsp.pslverr = ~hit(apb_i.paddr);
            if (!apb_i.pwrite && hit(apb_i.paddr))
            begin
                s_d.rsp.prdata = rd(idx, s_q);
            end
        end

        // lowest priority source first so later ones override conflicts
        m = s_q.mask_hi;
        if (strobe_i.aux_bit_clr)
        begin
            m[rxexc_pkg::HI_BIT_AUX] = 1'b0;
        end
        if (strobe_i.aux_bit_set)
        begin
            m[rxexc_pkg::HI_BIT_AUX] = 1'b1;
        end
        if (strobe_i.mask_and)
        begin
            m = m & strobe_i.operand;
        end
        if (strobe_i.mask_or)
        begin
            m = m | strobe_i.operand;
        end
        if (strobe_i.rx_on_strobe)
        begin
            m[rxexc_pkg::HI_BIT_RX_ON] = 1'b1;
        end
        if (strobe_i.tx_on_strobe && tx_on_sets_mask_i)
        begin
            m[rxexc_pkg::HI_BIT_TX_ON] = 1'b1;
        end
        if (strobe_i.radio_off_strobe)
        begin
            m = rxexc_pkg::RST_MASK_HIGH; // RULE9
        end
        if (wr && idx == rxexc_pkg::IDX_MASK_HIGH)
        begin
            m = apb_i.pwdata[7:0]; // RULE10
        end
        s_d.mask_hi = m; // RULE1

        // write-zero clears; a written one keeps the stored value
        if (wr && idx == rxexc_pkg::IDX_FLAGS_LOW)
        begin
            s_d.flags[7:0] = s_q.flags[7:0] & apb_i.pwdata[7:0]; // RULE4
        end
        if (wr && idx == rxexc_pkg::IDX_FLAGS_HIGH)
        begin
            s_d.flags[15:8] = s_q.flags[15:8] & apb_i.pwdata[7:0]; // RULE4
        end
        // set after clear so a coincident event survives
        s_d.flags = s_d.flags | ev; // RULE11

        if (wr && idx == rxexc_pkg::IDX_IRQ_STATUS)
        begin
            s_d.irq_sts = s_q.irq_sts & ~apb_i.pwdata[15:0];
        end
        s_d.irq_sts = s_d.irq_sts | ev;
        if (wr && idx == rxexc_pkg::IDX_IRQ_MASK)
        begin
            s_d.irq_msk = apb_i.pwdata[15:0];
        end
        s_d.irq = |(s_d.irq_sts & s_d.irq_msk);

        s_d.was_nonzero = (full_mask != 16'h0000);
        s_d.rx_enable   = (full_mask != 16'h0000); // RULE8
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_q.rsp         <= '0;
            s_q.mask_hi     <= rxexc_pkg::RST_MASK_HIGH; // RULE2
            s_q.flags       <= rxexc_pkg::RST_FLAGS; // RULE7
            s_q.irq_sts     <= rxexc_pkg::RST_IRQ;
            s_q.irq_msk     <= rxexc_pkg::RST_IRQ;
            s_q.irq         <= 1'b0;
            s_q.rx_enable   <= 1'b0;
            s_q.was_nonzero <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign apb_o       = s_q.rsp;
    assign mask_high_o = s_q.mask_hi;
    assign flags_o     = s_q.flags; // RULE5
    assign rx_enable_o = s_q.rx_enable;
    assign irq_o       = s_q.irq;

    property p_mask_reset;
        @(posedge clk_i)
        !rst_n_i |=> (mask_high_o == rxexc_pkg::RST_MASK_HIGH);
    endproperty
    a_mask_reset: assert property (p_mask_reset) // RULE2
        else $error("mask high byte not zero after reset");

    property p_flags_reset;
        @(posedge clk_i)
        !rst_n_i |=> (flags_o == rxexc_pkg::RST_FLAGS) && !irq_o;
    endproperty
    a_flags_reset: assert property (p_flags_reset) // RULE7
        else $error("flags not zero after reset");

    property p_event_sets;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ev != 16'h0000) |=> ((flags_o & $past(ev)) == $past(ev));
    endproperty
    a_event_sets: assert property (p_event_sets) // RULE3
        else $error("event did not set its flag");

    property p_no_spurious_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> ((flags_o & ~$past(flags_o) & ~$past(ev)) == 16'h0000);
    endproperty
    a_no_spurious_set: assert property (p_no_spurious_set) // RULE4
        else $error("flag rose without an event");

    property p_write_zero_clears;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && idx == rxexc_pkg::IDX_FLAGS_LOW)
        |=> (flags_o[7:0] == (($past(flags_o[7:0])
             & $past(apb_i.pwdata[7:0])) | $past(ev[7:0])));
    endproperty
    a_write_zero_clears: assert property (p_write_zero_clears) // RULE11
        else $error("low flag write result wrong");

    property p_flags_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!wr && ev == 16'h0000) |=> $stable(flags_o);
    endproperty
    a_flags_hold: assert property (p_flags_hold) // RULE5
        else $error("flags changed without cause");

    property p_mask_zero_event;
        @(posedge clk_i) disable iff (!rst_n_i)
        ($past(full_mask) != 16'h0000 && full_mask == 16'h0000)
        |=> flags_o[rxexc_pkg::EXC_MASK_CLEARED];
    endproperty
    a_mask_zero_event: assert property (p_mask_zero_event) // RULE6
        else $error("mask-zero flag not raised");

    property p_bus_write_mask;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && idx == rxexc_pkg::IDX_MASK_HIGH)
        |=> (mask_high_o == $past(apb_i.pwdata[7:0]));
    endproperty
    a_bus_write_mask: assert property (p_bus_write_mask) // RULE10
        else $error("bus write to mask lost");

    property p_radio_off;
        @(posedge clk_i) disable iff (!rst_n_i)
        (strobe_i.radio_off_strobe
         && !(wr && idx == rxexc_pkg::IDX_MASK_HIGH))
        |=> (mask_high_o == rxexc_pkg::RST_MASK_HIGH);
    endproperty
    a_radio_off: assert property (p_radio_off) // RULE9
        else $error("radio off did not clear mask");

    property p_rx_enable;
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (rx_enable_o == ($past(full_mask) != 16'h0000));
    endproperty
    a_rx_enable: assert property (p_rx_enable) // RULE8
        else $error("receiver request does not track mask");

    property p_mask_readback;
        @(posedge clk_i) disable iff (!rst_n_i)
        (access && !apb_o.pready && !apb_i.pwrite
         && idx == rxexc_pkg::IDX_MASK_HIGH && apb_i.paddr[1:0] == 2'h0)
        |=> apb_o.pready
            && (apb_o.prdata == {24'h00_0000, $past(mask_high_o)});
    endproperty
    a_mask_readback: assert property (p_mask_readback) // RULE1
        else $error("mask byte read back wrong");

    property p_irq_level;
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (irq_o == (|(s_q.irq_sts & s_q.irq_msk)));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level inconsistent");

    property p_flags_high_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && idx == rxexc_pkg::IDX_FLAGS_HIGH)
        |=> (flags_o[15:8] == (($past(flags_o[15:8])
             & $past(apb_i.pwdata[7:0])) | $past(ev[15:8])));
    endproperty
    a_flags_high_write: assert property (p_flags_high_write) // RULE4
        else $error("high flag write result wrong");

    // an unmapped access must answer with an error and never with data
    property p_unmapped_error;
        @(posedge clk_i) disable iff (!rst_n_i)
        (access && !apb_o.pready && !hit(apb_i.paddr))
        |=> apb_o.pready && apb_o.pslverr
            && (apb_o.prdata == 32'h0000_0000);
    endproperty
    a_unmapped_error: assert property (p_unmapped_error)
        else $error("unmapped access not refused");

endmodule : rxexc_top

`default_nettype wire

//--- tb/rxexc_host.sv
// rxexc_host: apb master standing in for host software.
// assumes clk_i is the device clock and the slave raises pready.
`timescale 1ns/1ns
`default_nettype none

module rxexc_host (
    input  wire logic                      clk_i,
    input  wire rxexc_pkg::rxexc_apb_rsp_s rsp_i,
    output var  rxexc_pkg::rxexc_apb_req_s req_o
);
    initial req_o = '0;

    // the answer is read right after the rising edge, before the slave's
    // registers move, so it is the value sampled at that edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        rd = 32'h0000_0000;
        err = 1'b0;
        @(posedge clk_i);
        req_o <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge clk_i);
        req_o.penable <= 1'b1;
        while (n < 20 && !ok)
        begin
            @(posedge clk_i);
            n++;
            if (rsp_i.pready === 1'b1)
            begin
                ok = 1'b1;
                rd = rsp_i.prdata;
                err = rsp_i.pslverr;
            end
        end
        req_o <= '0;
    endtask : xfer
endmodule : rxexc_host

`default_nettype wire

//--- tb/tb.sv
// tb: register, event, strobe and interrupt tests of rxexc_top.
// assumes rxexc_host as apb master and one 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic                      clk_i;
    logic                      rst_n_i;
    rxexc_pkg::rxexc_apb_req_s apb_req;
    rxexc_pkg::rxexc_apb_rsp_s apb_rsp;
    rxexc_pkg::rxexc_strobe_s  strobe;
    logic                      tx_sets;
    logic [7:0]                mask_low;
    logic [15:0]               event_v;
    logic [7:0]                mask_high;
    logic [15:0]               flags;
    logic                      rx_en;
    logic                      irq;
    logic [31:0]               rdat;
    logic                      serr;
    int                        err_total;
    int                        checked;

    rxexc_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .apb_i(apb_req), .apb_o(apb_rsp), .strobe_i(strobe),
        .tx_on_sets_mask_i(tx_sets), .mask_low_i(mask_low),
        .event_i(event_v), .mask_high_o(mask_high), .flags_o(flags),
        .rx_enable_o(rx_en), .irq_o(irq));
    rxexc_host host (.clk_i(clk_i), .rsp_i(apb_rsp), .req_o(apb_req));

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    function automatic logic [7:0] ba(input logic [5:0] i);
        return {i, 2'b00};
    endfunction : ba

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        logic ok;
        host.xfer(wr, a, wd, rdat, serr, ok);
        if (!ok)
        begin
            err_total++;
            $display("[ERR] pready expected 1 seen 0");
            print_verdict();
        end
    endtask : bus

    task automatic rdc(input string what, input logic [5:0] i,
                       input logic [31:0] exp);
        bus(1'b0, ba(i), 32'h0000_0000);
        chk(what, exp, rdat);
    endtask : rdc

    task automatic pulse(input logic [15:0] ev);
        @(posedge clk_i);
        event_v <= ev;
        @(posedge clk_i);
        event_v <= 16'h0000;
        repeat (2) @(negedge clk_i);
    endtask : pulse

    task automatic strb(input logic [14:0] s, input logic [7:0] exp);
        @(posedge clk_i);
        strobe <= s;
        @(posedge clk_i);
        strobe <= '0;
        @(negedge clk_i);
        chk("mask high out", {24'h0000_00, exp}, {24'h0000_00, mask_high});
    endtask : strb

    initial
    begin
        #100000;
        err_total++;
        $display("[ERR] run time expected short seen long");
        print_verdict();
    end

    initial
    begin
        err_total = 0;
        checked = 0;
        rst_n_i = 1'b0;
        strobe = '0;
        tx_sets = 1'b1;
        mask_low = 8'h00;
        event_v = 16'h0000;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rdc("mask high", rxexc_pkg::IDX_MASK_HIGH, 32'h0000_0000);
        rdc("flags low", rxexc_pkg::IDX_FLAGS_LOW, 32'h0000_0000);
        rdc("flags high", rxexc_pkg::IDX_FLAGS_HIGH, 32'h0000_0000);
        rdc("irq mask", rxexc_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        $display("test reset done");
        bus(1'b1, ba(rxexc_pkg::IDX_MASK_HIGH), 32'h0000_00a5);
        rdc("mask high", rxexc_pkg::IDX_MASK_HIGH, 32'h0000_00a5);
        @(negedge clk_i);
        chk("rx enable", 32'h0000_0001, {31'h0, rx_en});
        bus(1'b1, ba(rxexc_pkg::IDX_MASK_HIGH), 32'h0000_0000);
        repeat (2) @(negedge clk_i);
        chk("rx enable", 32'h0000_0000, {31'h0, rx_en});
        rdc("flags low", rxexc_pkg::IDX_FLAGS_LOW, 32'h0000_0080);
        $display("test mask done");
        bus(1'b1, ba(rxexc_pkg::IDX_FLAGS_LOW), 32'h0000_0000);
        for (int i = 0; i < 7; i++)
        begin
            pulse(16'h0001 << i);
            rdc("flags low", rxexc_pkg::IDX_FLAGS_LOW,
                (32'h0000_0001 << (i + 1)) - 1);
        end
        pulse(16'hff00);
        rdc("flags high", rxexc_pkg::IDX_FLAGS_HIGH, 32'h0000_00ff);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        bus(1'b1, ba(rxexc_pkg::IDX_FLAGS_LOW), 32'h0000_00ff);
        rdc("flags low", rxexc_pkg::IDX_FLAGS_LOW, 32'h0000_007f);
        bus(1'b1, ba(rxexc_pkg::IDX_FLAGS_LOW), 32'h0000_00f5);
        rdc("flags low", rxexc_pkg::IDX_FLAGS_LOW, 32'h0000_0075);
        // event lands on the very edge that completes the clearing write
        fork
            bus(1'b1, ba(rxexc_pkg::IDX_FLAGS_LOW), 32'h0000_0000);
            begin
                repeat (3) @(posedge clk_i);
                event_v <= 16'h0001;
                @(posedge clk_i);
                event_v <= 16'h0000;
            end
        join
        rdc("flags low", rxexc_pkg::IDX_FLAGS_LOW, 32'h0000_0001);
        chk("flags out", 32'h0000_ff01, {16'h0000, flags});
        $display("test flags done");
        bus(1'b1, ba(rxexc_pkg::IDX_IRQ_MASK), 32'h0000_0001);
        rdc("irq mask", rxexc_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        chk("irq raised", 32'h0000_0001, {31'h0, irq});
        bus(1'b1, ba(rxexc_pkg::IDX_IRQ_STATUS), 32'h0000_0001);
        rdc("irq status", rxexc_pkg::IDX_IRQ_STATUS, 32'h0000_fffe);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        $display("test irq done");
        strb(15'h2000, 8'h80);
        strb(15'h1000, 8'hc0);
        strb(15'h0200, 8'he0);
        strb(15'h0100, 8'hc0);
        strb(15'h0803, 8'hc3);
        strb(15'h040f, 8'h03);
        strb(15'h6000, 8'h00);
        @(posedge clk_i);
        tx_sets <= 1'b0;
        strb(15'h1000, 8'h00);
        // radio off lands on the edge of a bus write to the mask
        fork
            bus(1'b1, ba(rxexc_pkg::IDX_MASK_HIGH), 32'h0000_0011);
            begin
                repeat (3) @(posedge clk_i);
                strobe <= 15'h4000;
                @(posedge clk_i);
                strobe <= '0;
            end
        join
        rdc("mask high", rxexc_pkg::IDX_MASK_HIGH, 32'h0000_0011);
        chk("mask high out", 32'h0000_0011, {24'h00_0000, mask_high});
        bus(1'b0, 8'h80, 32'h0000_0000);
        chk("slave error", 32'h0000_0001, {31'h0, serr});
        chk("unmapped data", 32'h0000_0000, rdat);
        $display("test strobes done");
        print_verdict();
    end
endmodule : tb

`default_nettype wire
